// ### dv/ppio_pins_model.sv
`timescale 1ns/1ps
// Board side of ports 3 and 4 as seen at the pins.
module ppio_pins_model (
	input wire logic        hclk,
	input wire logic [7:0]  port3_out,
	input wire logic [7:0]  port3_oe,
	input wire logic [7:0]  port4_out,
	input wire logic [7:0]  port4_oe,
	input wire logic [7:0]  board_p3,
	input wire logic [7:0]  board_p4,
	input wire logic [7:0]  board_en,
	output logic     [7:0]  port3_in,
	output logic     [7:0]  port4_in
);
	logic [7:0] float_r = 8'h55;
	// A floating line flips every cycle, so a stale level is never mistaken for data.
	always @(posedge hclk) float_r <= ~float_r;
	// The chip's drive wins, then the board's, then the floating pattern.
	assign port3_in = (port3_oe & port3_out) | (~port3_oe & ((board_en & board_p3) |
		(~board_en & float_r)));
	assign port4_in = (port4_oe & port4_out) | (~port4_oe & ((board_en & board_p4) |
		(~board_en & float_r)));
endmodule : ppio_pins_model

// ### dv/ppio_top_assertions.sv
`timescale 1ns/1ps
// Watches bus answers, pull-up gating and bus ownership of the pins.
module ppio_top_assertions (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [2:0]  op_mode,
	input wire logic        hw_standby_n,
	input wire logic [7:0]  area_bus_width_control,
	input wire logic [7:0]  port2_direction,
	input wire logic [7:0]  port2_pullup_en,
	input wire logic [7:0]  port3_out,
	input wire logic [7:0]  port3_oe,
	input wire logic [7:0]  port4_out,
	input wire logic [7:0]  port4_oe,
	input wire logic [15:0] ext_data_out,
	input wire logic        ext_data_oe
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Decodes; the mode and standby pins pass two sync flops, hence the long antecedents.
	wire        rd_go  = hsel && hready && htrans[1] && !hwrite;
	wire [15:0] idx    = haddr[17:2];
	wire        exp_m  = op_mode != ppio_pkg::MODE_SINGLE;
	wire        addr_m = op_mode <= ppio_pkg::MODE_ADDR_LAST;
	wire        wide   = area_bus_width_control != 8'h00;

	pu_gate_a: assert property ((port2_pullup_en & $past(port2_direction)) == 8'h00)
		else $error("pull-up on an output pin");
	pu_addr_off_a: assert property (addr_m [*4] |-> port2_pullup_en == 8'h00)
		else $error("pull-up on in an address mode");
	hwstby_off_a: assert property (!hw_standby_n [*4] |->
		{port2_pullup_en, port3_oe, port4_oe} == 24'h000000)
		else $error("pin active in hardware standby");
	rd_wait_a: assert property (rd_go |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	dir_ones_a: assert property (rd_go &&
		(idx == ppio_pkg::IDX_P3_DIR || idx == ppio_pkg::IDX_P4_DIR) |=> ##1
		hrdata == 32'h000000ff)
		else $error("direction read not all ones");
	p3_bus_a: assert property ((exp_m && hw_standby_n && $stable(ext_data_out) &&
		$stable(ext_data_oe)) [*5] |-> port3_out == ext_data_out[15:8] &&
		port3_oe == {8{ext_data_oe}})
		else $error("port 3 not on the data bus");
	p4_bus_a: assert property ((exp_m && wide && hw_standby_n &&
		$stable(ext_data_out) && $stable(ext_data_oe)) [*5] |->
		port4_out == ext_data_out[7:0] && port4_oe == {8{ext_data_oe}})
		else $error("port 4 not on the data bus");
	okay_a: assert property (hresp == ppio_pkg::HRESP_OKAY)
		else $error("response not okay");
	cover property (rd_go);
	cover property (!hw_standby_n [*4]);
	cover property (port2_pullup_en != 8'h00);
endmodule : ppio_top_assertions

bind ppio_top ppio_top_assertions u_ppio_top_assertions (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .op_mode(op_mode), .hw_standby_n(hw_standby_n),
	.area_bus_width_control(area_bus_width_control), .port2_direction(port2_direction),
	.port2_pullup_en(port2_pullup_en), .port3_out(port3_out), .port3_oe(port3_oe),
	.port4_out(port4_out), .port4_oe(port4_oe), .ext_data_out(ext_data_out),
	.ext_data_oe(ext_data_oe)
);

// ### dv/ppio_top_bench.sv
`timescale 1ns/1ps
// Drives the bus, the mode and standby pins and the board, and checks the results.
module ppio_top_bench;
	typedef struct {
		logic [15:0] idx;
		logic [7:0]  wd;
		logic [7:0]  pins;
		logic [7:0]  exp_rd;
	} ppio_row_t;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic [2:0]  op_mode = 3'h7;
	logic        hw_standby_n = 1'b1;
	logic        sw_standby = 1'b0;
	logic [7:0]  area_bus_width_control = 8'h00;
	logic [7:0]  port2_direction = 8'h01;
	logic [15:0] ext_data_out = 16'h9ce1;
	logic        ext_data_oe = 1'b1;
	logic [7:0]  board_p3 = 8'h00, board_p4 = 8'h00, board_en = 8'hff;
	logic [31:0] rd;
	wire  [31:0] hrdata;
	wire         hreadyout, hresp;
	wire  [7:0]  port2_pullup_en, port3_in, port3_out, port3_oe;
	wire  [7:0]  port4_in, port4_out, port4_oe, port4_pullup_ctl;
	wire  [15:0] ext_data_in;
	int          failures = 0, total_checks = 0, cyc = 0;
	ppio_row_t   rows [7];

	// Clock; the single slave's ready is the bus ready.
	always #5 hclk = ~hclk;
	wire hready = hreadyout;

	ppio_top u_ppio_top (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .op_mode(op_mode),
		.hw_standby_n(hw_standby_n), .sw_standby(sw_standby),
		.area_bus_width_control(area_bus_width_control), .port2_direction(port2_direction),
		.port2_pullup_en(port2_pullup_en), .port3_in(port3_in), .port3_out(port3_out),
		.port3_oe(port3_oe), .port4_in(port4_in), .port4_out(port4_out),
		.port4_oe(port4_oe), .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe),
		.ext_data_in(ext_data_in), .port4_pullup_ctl(port4_pullup_ctl));
	ppio_pins_model u_ppio_pins_model (.hclk(hclk), .port3_out(port3_out),
		.port3_oe(port3_oe), .port4_out(port4_out), .port4_oe(port4_oe),
		.board_p3(board_p3), .board_p4(board_p4), .board_en(board_en),
		.port3_in(port3_in), .port4_in(port4_in));

	task automatic end_sim();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_sim

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One single word transfer; each phase is held until ready is sampled high.
	task automatic bus(input logic [15:0] idx, input logic wr, input logic [7:0] wd);
		@(posedge hclk);
		haddr <= {14'h0000, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h000000, wd};
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus

	// A hang is cut short well above the length of the whole sequence.
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			failures++;
			end_sim();
		end
	end

	initial begin
		rows = '{'{ppio_pkg::IDX_P3_DIR, 8'h0f, 8'h00, 8'hff},
			'{ppio_pkg::IDX_P3_DATA, 8'ha5, 8'h3c, 8'h35},
			'{ppio_pkg::IDX_P4_DIR, 8'hf0, 8'h00, 8'hff},
			'{ppio_pkg::IDX_P4_DATA, 8'h5a, 8'hc3, 8'h53},
			'{ppio_pkg::IDX_P2_PUC, 8'h81, 8'h00, 8'h81},
			'{ppio_pkg::IDX_P4_PUC, 8'h7e, 8'h00, 8'h7e},
			'{16'hffd0, 8'h55, 8'h00, 8'h00}};
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		chk("oe3", 8'h00, port3_oe);
		chk("pu2", 8'h00, port2_pullup_en);
		bus(ppio_pkg::IDX_P2_PUC, 1'b0, 8'h00);
		chk("p2 pull ctl", 32'h0, rd);
		foreach (rows[i]) begin
			board_p3 <= rows[i].pins;
			board_p4 <= rows[i].pins;
			bus(rows[i].idx, 1'b1, rows[i].wd);
			repeat (4) @(posedge hclk);
			bus(rows[i].idx, 1'b0, 8'h00);
			chk("row read", {24'h0, rows[i].exp_rd}, rd);
		end
		chk("oe3", 8'h0f, port3_oe);
		chk("out3", 8'ha5, port3_out);
		chk("oe4", 8'hf0, port4_oe);
		chk("pu2", 8'h80, port2_pullup_en);
		// Software standby keeps every setting and every driven pin.
		sw_standby <= 1'b1;
		board_p3 <= 8'h3c;
		repeat (4) @(posedge hclk);
		chk("oe3", 8'h0f, port3_oe);
		chk("out3", 8'ha5, port3_out);
		chk("pu2", 8'h80, port2_pullup_en);
		chk("ext in", 32'h3550, ext_data_in);
		chk("pu4 ctl", 32'h7e, port4_pullup_ctl);
		bus(ppio_pkg::IDX_P3_DATA, 1'b0, 8'h00);
		chk("p3 data", 32'h35, rd);
		sw_standby <= 1'b0;
		board_en <= 8'h00;
		for (int m = 1; m <= 7; m++) begin
			op_mode <= 3'(m);
			repeat (6) @(posedge hclk);
			chk("pu2", (m >= 5) ? 8'h80 : 8'h00, port2_pullup_en);
			chk("oe3", (m == 7) ? 8'h0f : 8'hff, port3_oe);
			chk("out3", (m == 7) ? 8'ha5 : 8'h9c, port3_out);
			chk("oe4", 8'hf0, port4_oe);
		end
		area_bus_width_control <= 8'h04;
		repeat (6) @(posedge hclk);
		chk("oe4", 8'hf0, port4_oe);
		op_mode <= 3'h5;
		repeat (6) @(posedge hclk);
		chk("oe4", 8'hff, port4_oe);
		chk("out4", 8'he1, port4_out);
		op_mode <= 3'h7;
		area_bus_width_control <= 8'h00;
		repeat (6) @(posedge hclk);
		// Hardware standby turns everything off and clears the registers.
		hw_standby_n <= 1'b0;
		repeat (5) @(posedge hclk);
		chk("oe3", 8'h00, port3_oe);
		chk("pu2", 8'h00, port2_pullup_en);
		hw_standby_n <= 1'b1;
		repeat (5) @(posedge hclk);
		chk("oe3", 8'h00, port3_oe);
		chk("out3", 8'h00, port3_out);
		chk("oe4", 8'h00, port4_oe);
		bus(ppio_pkg::IDX_P2_PUC, 1'b0, 8'h00);
		chk("p2 pull ctl", 32'h0, rd);
		// A reset in mid-run clears a setting made just before it.
		bus(ppio_pkg::IDX_P2_PUC, 1'b1, 8'h81);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("pu2", 8'h00, port2_pullup_en);
		bus(ppio_pkg::IDX_P2_PUC, 1'b0, 8'h00);
		chk("p2 pull ctl", 32'h0, rd);
		end_sim();
	end
endmodule : ppio_top_bench

// ### rtl/ppio_pkg.sv
// Contract
// (R1) Modes 5-7: port 2 pull-up on only if direction 0 and control 1.
// (R2) Port 2 pull-up control clears on reset and hardware standby, kept in software standby.
// (R3) Modes 1-4 port 2 pull-ups always off; off in reset and hardware standby.
// (R4) Modes 5-7 pull-up gating holds in software standby and normal operation.
// (R5) Modes 1-6 port 3 is the data bus, direction ignored; mode 7 is I/O.
// (R6) Single-chip mode: port 3 pin drives when direction 1, input when 0.
// (R7) Port 3 direction is write-only; reads return all ones.
// (R8) Port 3 direction clears on reset and hardware standby, kept in software standby.
// (R9) In software standby a port 3 output pin keeps driving its state.
// (R10) Port 3 data read gives stored bit if direction 1, pin level if 0.
// (R11) Port 3 data is read/write, clears on reset and hardware standby, kept otherwise.
// (R12) Expanded modes with all areas 8-bit: 8-bit bus, port 4 general I/O.
// (R13) Expanded modes with any area 16-bit: port 4 joins the data bus.
// (R14) Port 4 as general I/O: direction 1 drives, direction 0 input.
// (R15) Port 4 direction is write-only at index ffc5, reset value zero.
// (R16) Port 3 registers at indices ffc4 and ffc6; low 16 index bits decoded.
// (R17) Modes 1-4 port 2 carries upper address, so its pull-ups stay off.
// (R18) Port 4 data read gives stored bit if direction 1, pin level if 0.
// (R19) A port serving as bus takes output value and enable from the bus interface.
package ppio_pkg;

	// ****************************************************************
	// Register indices; byte address is four times the index.
	// ****************************************************************
	localparam int unsigned IDX_W   = 16;
	localparam int unsigned IDX_LSB = 2;
	localparam logic [15:0] IDX_P3_DIR  = 16'hffc4;
	localparam logic [15:0] IDX_P4_DIR  = 16'hffc5;
	localparam logic [15:0] IDX_P3_DATA = 16'hffc6;
	localparam logic [15:0] IDX_P4_DATA = 16'hffc7;
	localparam logic [15:0] IDX_P2_PUC  = 16'hffd8;
	localparam logic [15:0] IDX_P4_PUC  = 16'hffda;

	// ****************************************************************
	// Widths and values.
	// ****************************************************************
	localparam int unsigned PORT_W = 8;
	localparam int unsigned MODE_W = 3;
	localparam int unsigned AREA_N = 8;
	localparam int unsigned DATA_W = 32;
	localparam logic [7:0]  REG_RESET    = 8'h00;
	localparam logic [7:0]  DIR_READBACK = 8'hff;
	localparam logic [23:0] RDATA_PAD    = 24'h000000;
	localparam logic [31:0] RDATA_NONE   = 32'h00000000;

	// ****************************************************************
	// Operating modes.
	// ****************************************************************
	localparam logic [2:0] MODE_FIRST        = 3'h1;
	localparam logic [2:0] MODE_ADDR_LAST    = 3'h4;
	localparam logic [2:0] MODE_PULLUP_FIRST = 3'h5;
	localparam logic [2:0] MODE_SINGLE       = 3'h7;

	// ****************************************************************
	// Bus encodings.
	// ****************************************************************
	localparam int unsigned HTRANS_ACT_BIT = 1;
	localparam logic [2:0]  HSIZE_WORD     = 3'h2;
	localparam logic        HRESP_OKAY     = 1'b0;
	localparam logic        AREA_16BIT     = 1'b1;

endpackage : ppio_pkg

// ### rtl/ppio_top.sv
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module ppio_top (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [2:0]  op_mode,
	input  wire logic        hw_standby_n,
	input  wire logic        sw_standby,
	input  wire logic [7:0]  area_bus_width_control,
	input  wire logic [7:0]  port2_direction,
	output logic      [7:0]  port2_pullup_en,
	input  wire logic [7:0]  port3_in,
	output logic      [7:0]  port3_out,
	output logic      [7:0]  port3_oe,
	input  wire logic [7:0]  port4_in,
	output logic      [7:0]  port4_out,
	output logic      [7:0]  port4_oe,
	input  wire logic [15:0] ext_data_out,
	input  wire logic        ext_data_oe,
	output logic      [15:0] ext_data_in,
	output logic      [7:0]  port4_pullup_ctl
);

	// ****************************************************************
	// Decoding helpers.
	// ****************************************************************

	// Per-bit readback: stored bit where the pin drives, live pin where it listens.
	function automatic logic [7:0] port_readback(
		input logic [7:0] dir,
		input logic [7:0] data,
		input logic [7:0] pin
	);
		port_readback = (dir & data) | (~dir & pin);
	endfunction : port_readback

	// Register hit test on the latched index, shared by read and write paths.
	function automatic logic idx_hit(
		input logic [15:0] idx,
		input logic [15:0] target
	);
		idx_hit = (idx == target);
	endfunction : idx_hit

	// ****************************************************************
	// Pin synchronisers.
	// ****************************************************************
	logic [2:0]  mode_meta_r;
	logic [2:0]  mode_sync_r;
	logic        hwsb_meta_r;
	logic        hwsb_sync_r;
	logic [7:0]  p3_meta_r;
	logic [7:0]  p3_sync_r;
	logic [7:0]  p4_meta_r;
	logic [7:0]  p4_sync_r;

	// Mode flops leave reset as single-chip so that no pin follows the data bus
	// before the straps have been seen twice.
	localparam logic [2:0] MODE_SINGLE_RST = ppio_pkg::MODE_SINGLE;

	// Mode straps, standby pin and port pins all arrive from outside the clock.
	// The standby pin resets to asserted so the ports stay quiet until it is seen.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_meta_r <= MODE_SINGLE_RST;
			mode_sync_r <= MODE_SINGLE_RST;
			hwsb_meta_r <= 1'b0;
			hwsb_sync_r <= 1'b0;
			p3_meta_r   <= ppio_pkg::REG_RESET;
			p3_sync_r   <= ppio_pkg::REG_RESET;
			p4_meta_r   <= ppio_pkg::REG_RESET;
			p4_sync_r   <= ppio_pkg::REG_RESET;
		end else begin
			mode_meta_r <= op_mode;
			mode_sync_r <= mode_meta_r;
			hwsb_meta_r <= hw_standby_n;
			hwsb_sync_r <= hwsb_meta_r;
			p3_meta_r   <= port3_in;
			p3_sync_r   <= p3_meta_r;
			p4_meta_r   <= port4_in;
			p4_sync_r   <= p4_meta_r;
		end
	end

	// ****************************************************************
	// Mode decoding.
	// ****************************************************************
	wire hw_standby;
	wire single_chip;
	wire addr_only_mode;
	wire pullup_mode;
	wire bus16_mode;
	wire port4_gpio;

	// Mode 0 is no legal strap; it is taken as expanded with pull-ups off, the
	// quietest choice, which never leaves a data pin fighting the bus.
	// Hardware standby acts only after the pin has passed both flops.
	assign hw_standby     = ~hwsb_sync_r;
	assign single_chip    = (mode_sync_r == ppio_pkg::MODE_SINGLE);
	assign addr_only_mode = (mode_sync_r >= ppio_pkg::MODE_FIRST)
	                      & (mode_sync_r <= ppio_pkg::MODE_ADDR_LAST); // R17
	assign pullup_mode    = (mode_sync_r >= ppio_pkg::MODE_PULLUP_FIRST); // R1 R3

	// Any area flagged for 16-bit access widens the external bus.
	assign bus16_mode = ~single_chip
	                  & (|(area_bus_width_control ~^ {ppio_pkg::AREA_N{ppio_pkg::AREA_16BIT}})); // R13
	assign port4_gpio = ~bus16_mode; // R12

	// ****************************************************************
	// Bus slave: address and data phases.
	// ****************************************************************
	logic        wr_pend_r;
	logic        rd_pend_r;
	logic [15:0] idx_r;
	logic        hreadyout_r;
	logic [31:0] hrdata_r;
	wire         addr_phase;
	wire         word_size;

	// Only whole-word writes change registers; narrow writes complete with no effect, narrow reads still return data.
	// A stray narrow access still answers OKAY, so it can never stall the bus;
	// it simply changes nothing.
	assign addr_phase = hsel & hready & htrans[ppio_pkg::HTRANS_ACT_BIT];
	assign word_size  = (hsize == ppio_pkg::HSIZE_WORD);

	// Writes finish without wait; a read inserts one wait state so that
	// the returned word reflects any write that ended on the same edge.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r   <= 1'b0;
			rd_pend_r   <= 1'b0;
			idx_r       <= '0;
			hreadyout_r <= 1'b1;
		end else if (addr_phase) begin
			wr_pend_r   <= hwrite & word_size;
			rd_pend_r   <= ~hwrite;
			idx_r       <= haddr[ppio_pkg::IDX_LSB +: ppio_pkg::IDX_W]; // R16
			hreadyout_r <= hwrite;
		end else begin
			wr_pend_r   <= 1'b0;
			rd_pend_r   <= 1'b0;
			hreadyout_r <= 1'b1;
		end
	end

	// ****************************************************************
	// Write strobes.
	// ****************************************************************
	wire we_p3_dir;
	wire we_p4_dir;
	wire we_p3_data;
	wire we_p4_data;
	wire we_p2_puc;
	wire we_p4_puc;
	wire [7:0] wbyte;

	// Narrow registers sit in the low byte lane of the word.
	assign wbyte      = hwdata[ppio_pkg::PORT_W-1:0];
	assign we_p3_dir  = wr_pend_r & idx_hit(idx_r, ppio_pkg::IDX_P3_DIR);
	assign we_p4_dir  = wr_pend_r & idx_hit(idx_r, ppio_pkg::IDX_P4_DIR);
	assign we_p3_data = wr_pend_r & idx_hit(idx_r, ppio_pkg::IDX_P3_DATA);
	assign we_p4_data = wr_pend_r & idx_hit(idx_r, ppio_pkg::IDX_P4_DATA);
	assign we_p2_puc  = wr_pend_r & idx_hit(idx_r, ppio_pkg::IDX_P2_PUC);
	assign we_p4_puc  = wr_pend_r & idx_hit(idx_r, ppio_pkg::IDX_P4_PUC);

	// ****************************************************************
	// Register file.
	// ****************************************************************
	logic [7:0] port3_direction_r;
	logic [7:0] port4_direction_r;
	logic [7:0] port3_output_data_r;
	logic [7:0] port4_output_data_r;
	logic [7:0] port2_pullup_control_r;
	logic [7:0] port4_pullup_control_r;

	// The direction registers are stored although they read back as ones,
	// since the pin enables and the data readback mix use their value.
	// Hardware standby clears everything; software standby is not looked at
	// here, so every setting simply holds through it.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port3_direction_r      <= ppio_pkg::REG_RESET; // R8
			port4_direction_r      <= ppio_pkg::REG_RESET; // R15
			port3_output_data_r    <= ppio_pkg::REG_RESET; // R11
			port4_output_data_r    <= ppio_pkg::REG_RESET;
			port2_pullup_control_r <= ppio_pkg::REG_RESET; // R2
			port4_pullup_control_r <= ppio_pkg::REG_RESET;
		end else if (hw_standby) begin
			port3_direction_r      <= ppio_pkg::REG_RESET; // R8
			port4_direction_r      <= ppio_pkg::REG_RESET; // R15
			port3_output_data_r    <= ppio_pkg::REG_RESET; // R11
			port4_output_data_r    <= ppio_pkg::REG_RESET;
			port2_pullup_control_r <= ppio_pkg::REG_RESET; // R2
			port4_pullup_control_r <= ppio_pkg::REG_RESET;
		end else begin
			if (we_p3_dir) begin
				port3_direction_r <= wbyte;
			end
			if (we_p4_dir) begin
				port4_direction_r <= wbyte;
			end
			if (we_p3_data) begin
				port3_output_data_r <= wbyte; // R11
			end
			if (we_p4_data) begin
				port4_output_data_r <= wbyte;
			end
			if (we_p2_puc) begin
				port2_pullup_control_r <= wbyte; // R2
			end
			if (we_p4_puc) begin
				port4_pullup_control_r <= wbyte;
			end
		end
	end

	// ****************************************************************
	// Read path.
	// ****************************************************************
	wire [7:0] p3_readback;
	wire [7:0] p4_readback;
	wire [7:0] rd_byte;

	// Data reads mix stored bits and synchronised pin levels bit by bit.
	assign p3_readback = port_readback(port3_direction_r, port3_output_data_r, p3_sync_r); // R10
	assign p4_readback = port_readback(port4_direction_r, port4_output_data_r, p4_sync_r); // R18

	// Direction registers cannot be read back; unmapped indices read zero.
	assign rd_byte =
		idx_hit(idx_r, ppio_pkg::IDX_P3_DIR)  ? ppio_pkg::DIR_READBACK : // R7
		idx_hit(idx_r, ppio_pkg::IDX_P4_DIR)  ? ppio_pkg::DIR_READBACK : // R15
		idx_hit(idx_r, ppio_pkg::IDX_P3_DATA) ? p3_readback :
		idx_hit(idx_r, ppio_pkg::IDX_P4_DATA) ? p4_readback :
		idx_hit(idx_r, ppio_pkg::IDX_P2_PUC)  ? port2_pullup_control_r :
		idx_hit(idx_r, ppio_pkg::IDX_P4_PUC)  ? port4_pullup_control_r :
		ppio_pkg::REG_RESET;

	// Read data is registered at the end of the wait cycle and held after.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= ppio_pkg::RDATA_NONE;
		end else if (rd_pend_r) begin
			hrdata_r <= {ppio_pkg::RDATA_PAD, rd_byte};
		end
	end

	// ****************************************************************
	// Pin drive selection.
	// ****************************************************************
	wire [7:0] p3_out_nxt;
	wire [7:0] p3_oe_nxt;
	wire [7:0] p4_out_nxt;
	wire [7:0] p4_oe_nxt;
	wire [7:0] pu_nxt;

	// Hardware standby overrides every other source, so no pin is driven while
	// the rest of the chip may be without power.
	// Port 3 carries the upper data byte outside single-chip mode and then
	// follows the bus interface; its direction register has no say there.
	assign p3_out_nxt = single_chip ? port3_output_data_r
	                                : ext_data_out[15:8]; // R5 R19
	assign p3_oe_nxt  = hw_standby  ? ppio_pkg::REG_RESET :
	                    single_chip ? port3_direction_r : // R6 R9
	                    {ppio_pkg::PORT_W{ext_data_oe}}; // R5 R19

	// Port 4 carries the lower data byte only in 16-bit bus mode.
	assign p4_out_nxt = port4_gpio ? port4_output_data_r
	                               : ext_data_out[7:0]; // R19
	assign p4_oe_nxt  = hw_standby ? ppio_pkg::REG_RESET :
	                    port4_gpio ? port4_direction_r : // R14
	                    {ppio_pkg::PORT_W{ext_data_oe}}; // R13 R19

	// Pull-ups follow the same gate in software standby as in normal running,
	// which is why sw_standby does not appear in this term.
	assign pu_nxt = (hw_standby | addr_only_mode | ~pullup_mode) ? ppio_pkg::REG_RESET // R3 R17
	              : (port2_pullup_control_r & ~port2_direction); // R1 R4

	// ****************************************************************
	// Output flops.
	// ****************************************************************
	logic [7:0]  port2_pullup_en_r;
	logic [7:0]  port3_out_r;
	logic [7:0]  port3_oe_r;
	logic [7:0]  port4_out_r;
	logic [7:0]  port4_oe_r;
	logic [15:0] ext_data_in_r;
	logic [7:0]  port4_pullup_ctl_r;
	logic        hresp_r;

	// The bus interface receives synchronised pin levels, so a data byte
	// reaches it three edges after it appears on the pins.
	// Every pin output comes from a flop, costing one cycle of latency;
	// under reset all enables and pull-ups are off.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port2_pullup_en_r  <= ppio_pkg::REG_RESET; // R3
			port3_out_r        <= ppio_pkg::REG_RESET;
			port3_oe_r         <= ppio_pkg::REG_RESET;
			port4_out_r        <= ppio_pkg::REG_RESET;
			port4_oe_r         <= ppio_pkg::REG_RESET;
			ext_data_in_r      <= '0;
			port4_pullup_ctl_r <= ppio_pkg::REG_RESET;
			hresp_r            <= ppio_pkg::HRESP_OKAY;
		end else begin
			port2_pullup_en_r  <= pu_nxt;
			port3_out_r        <= p3_out_nxt;
			port3_oe_r         <= p3_oe_nxt;
			port4_out_r        <= p4_out_nxt;
			port4_oe_r         <= p4_oe_nxt;
			ext_data_in_r      <= {p3_sync_r, p4_sync_r};
			port4_pullup_ctl_r <= port4_pullup_control_r;
			hresp_r            <= ppio_pkg::HRESP_OKAY;
		end
	end

	// Software standby needs no special handling: the flops above keep running,
	// so driven pins keep their level and settings stay as they were.
	wire unused_sw_standby;
	assign unused_sw_standby = sw_standby;

	// ****************************************************************
	// Output connections.
	// ****************************************************************
	assign hrdata           = hrdata_r;
	assign hreadyout        = hreadyout_r;
	assign hresp            = hresp_r;
	assign port2_pullup_en  = port2_pullup_en_r;
	assign port3_out        = port3_out_r;
	assign port3_oe         = port3_oe_r;
	assign port4_out        = port4_out_r;
	assign port4_oe         = port4_oe_r;
	assign ext_data_in      = ext_data_in_r;
	assign port4_pullup_ctl = port4_pullup_ctl_r;

endmodule : ppio_top
